// ===== bank_decode_pkg.sv
// Package for the memory bank select decoder.
// Assumes a single 40 MHz reference clock and an active-low reset.
`default_nettype none
package bank_decode_pkg;
  // Bank indices in the one-hot select vector.
  localparam int unsigned BANK_ROM1 = 0;
  localparam int unsigned BANK_RAM1 = 1;
  localparam int unsigned BANK_RAM2 = 2;
  localparam int unsigned BANK_ROM2 = 3;
  localparam int unsigned NUM_BANKS = 4;
  // Address bit positions used by the address-only model.
  localparam int unsigned ADDR_LO_BIT = 18;
  localparam int unsigned ADDR_HI_BIT = 19;
  localparam int unsigned ADDR_EXT_BIT = 21;
  localparam int unsigned ADDR_W = 24;
  // Mode values.
  localparam logic MODE_ADDRESS = 1'h0;
  localparam logic MODE_CHIP_SELECT = 1'h1;
  // Jumper values for the shared decoder input.
  localparam logic JUMPER_SELECT_THREE = 1'h0;
  localparam logic JUMPER_A21 = 1'h1;
  // Reset value of the synchronised mode and jumper straps.
  localparam logic [1:0] STRAP_RESET = 2'h2;
  // Memory timing figures, for reference by system integration.
  localparam int unsigned ACCESS_NS_WAIT = 70;
  localparam int unsigned BUS_CYCLE_NS = 150;
  localparam int unsigned ACCESS_NS_ZERO_WAIT = 55;
endpackage
`default_nettype wire

// ===== bank_lane_split.sv
// Splits one active-low bank select into low and high byte lane selects.
// Assumes combinational inputs from the same bus cycle.
`default_nettype none
module bank_lane_split
(
  // Bank select and byte steering
  input wire logic bank_n_i,
  input wire logic addr0_i,
  input wire logic high_byte_enable_n_i,
  // Lane selects
  output logic low_lane_n_o,
  output logic high_lane_n_o
);
  // A0 low enables the low byte; the high byte enable gates the high one.
  assign low_lane_n_o = bank_n_i | addr0_i;
  assign high_lane_n_o = bank_n_i | high_byte_enable_n_i;
endmodule // bank_lane_split
`default_nettype wire

// ===== bank_select_decoder.sv
// Memory bank select decoder: four active-low bank selects with lanes.
// Assumes bus inputs stable over a bus cycle; mode and jumper are straps.
`default_nettype none
module bank_select_decoder
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Straps
  input wire logic mode_i,
  input wire logic decoder_input_jumper_i,
  // Controller bus
  input wire logic [bank_decode_pkg::ADDR_W-1:0] addr_i,
  input wire logic high_byte_enable_n_i,
  input wire logic ctrl_chip_select_zero_n_i,
  input wire logic ctrl_chip_select_one_n_i,
  input wire logic ctrl_chip_select_two_n_i,
  input wire logic ctrl_chip_select_three_n_i,
  input wire logic ctrl_chip_select_four_n_i,
  // Bank selects, active low
  output logic [bank_decode_pkg::NUM_BANKS-1:0] bank_sel_n_o,
  output logic [bank_decode_pkg::NUM_BANKS-1:0] low_lane_n_o,
  output logic [bank_decode_pkg::NUM_BANKS-1:0] high_lane_n_o,
  // Chip selects freed for external use in mode 0
  output logic [3:0] free_chip_select_n_o,
  // Synchronised strap status
  output logic mode_o,
  output logic jumper_o
);
  import bank_decode_pkg::*;

  logic [1:0] rst_sync;
  logic rst_n;
  logic [1:0] strap_meta;
  logic [1:0] strap;
  logic [3:0] sel_cs;
  logic [3:0] sel_addr;
  logic shared_in;
  logic a18;
  logic a19;
  logic base_select_active;

  // Reset is released through two flops so all state leaves reset together.
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'h1};
    end
  end
  assign rst_n = rst_sync[1];

  // Straps come from pins, so they pass two flops before use.
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_meta <= STRAP_RESET;
      strap <= STRAP_RESET;
    end
    else
    begin
      strap_meta <= {mode_i, decoder_input_jumper_i};
      strap <= strap_meta;
    end
  end
  assign mode_o = strap[1];
  assign jumper_o = strap[0];

  // The shared decoder input carries either chip select 3 or A21.
  assign shared_in = (jumper_o == JUMPER_A21) ?
    addr_i[ADDR_EXT_BIT] : ctrl_chip_select_three_n_i;

  // Mode 1: controller chip selects route straight to the banks.
  // Priority to chip select 0 keeps one bank at most if software overlaps.
  always_comb
  begin
    sel_cs = 4'hF;
    if (!ctrl_chip_select_zero_n_i)
    begin
      sel_cs[BANK_ROM1] = 1'h0;
    end
    else if (!ctrl_chip_select_one_n_i)
    begin
      sel_cs[BANK_RAM1] = 1'h0;
    end
    else if (!ctrl_chip_select_two_n_i)
    begin
      sel_cs[BANK_RAM2] = 1'h0;
    end
    else if (jumper_o == JUMPER_SELECT_THREE && !shared_in)
    begin
      sel_cs[BANK_ROM2] = 1'h0;
    end
  end

  // Mode 0: only chip select 0 and address lines; A21 must be low if fitted.
  assign a18 = addr_i[ADDR_LO_BIT];
  assign a19 = addr_i[ADDR_HI_BIT];
  assign base_select_active = !ctrl_chip_select_zero_n_i &&
    !(jumper_o == JUMPER_A21 && shared_in);
  always_comb
  begin
    sel_addr = 4'hF;
    if (base_select_active)
    begin
      unique case ({a19, a18})
        2'h0: sel_addr[BANK_ROM1] = 1'h0;
        2'h1: sel_addr[BANK_RAM1] = 1'h0;
        2'h2: sel_addr[BANK_RAM2] = 1'h0;
        2'h3: sel_addr[BANK_ROM2] = 1'h0;
      endcase
    end
  end

  // Selection is purely combinational so no clock adds to access time.
  assign bank_sel_n_o = (mode_o == MODE_CHIP_SELECT) ?
    sel_cs : sel_addr;

  // In mode 0 the chip selects one to four are passed out for other use.
  assign free_chip_select_n_o = (mode_o == MODE_ADDRESS) ?
    {ctrl_chip_select_four_n_i, ctrl_chip_select_three_n_i,
     ctrl_chip_select_two_n_i, ctrl_chip_select_one_n_i} : 4'hF;

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++)
    begin : g_lane
      bank_lane_split u_lane
      (
        .bank_n_i(bank_sel_n_o[g]),
        .addr0_i(addr_i[0]),
        .high_byte_enable_n_i(high_byte_enable_n_i),
        .low_lane_n_o(low_lane_n_o[g]),
        .high_lane_n_o(high_lane_n_o[g])
      );
    end
  endgenerate

  a_one_hot_sel: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    $countones(~bank_sel_n_o) <= 1)
    else $error("More than one bank selected.");
  a_sel_rom1: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (mode_o && !ctrl_chip_select_zero_n_i) |-> !bank_sel_n_o[BANK_ROM1])
    else $error("Chip select 0 did not select ROM bank 1.");
  a_sel_ram1: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (mode_o && ctrl_chip_select_zero_n_i && !ctrl_chip_select_one_n_i)
    |-> !bank_sel_n_o[BANK_RAM1])
    else $error("Chip select 1 did not select RAM bank 1.");
  a_sel_ram2: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (mode_o && ctrl_chip_select_zero_n_i && ctrl_chip_select_one_n_i &&
    !ctrl_chip_select_two_n_i) |-> !bank_sel_n_o[BANK_RAM2])
    else $error("Chip select 2 did not select RAM bank 2.");
  a_sel_rom2: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (mode_o && !jumper_o && ctrl_chip_select_zero_n_i &&
    ctrl_chip_select_one_n_i && ctrl_chip_select_two_n_i &&
    !ctrl_chip_select_three_n_i) |-> !bank_sel_n_o[BANK_ROM2])
    else $error("Chip select 3 did not select ROM bank 2.");
  a_rom2_blocked: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (mode_o && (jumper_o || ctrl_chip_select_three_n_i))
    |-> bank_sel_n_o[BANK_ROM2])
    else $error("ROM bank 2 selected without chip select 3.");
  a_addr_decode: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (!mode_o && !ctrl_chip_select_zero_n_i &&
    !(jumper_o && addr_i[ADDR_EXT_BIT]))
    |-> !bank_sel_n_o[addr_i[ADDR_HI_BIT:ADDR_LO_BIT]])
    else $error("Address decode selected wrong bank.");
  a_a21_block: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (!mode_o && jumper_o && addr_i[ADDR_EXT_BIT]) |-> bank_sel_n_o == 4'hF)
    else $error("Bank selected with A21 high in mode 0.");
  a_mode0_idle: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (!mode_o && ctrl_chip_select_zero_n_i) |-> bank_sel_n_o == 4'hF)
    else $error("Bank selected without chip select 0 in mode 0.");
  a_free_pass: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    !mode_o |-> free_chip_select_n_o == {ctrl_chip_select_four_n_i,
    ctrl_chip_select_three_n_i, ctrl_chip_select_two_n_i,
    ctrl_chip_select_one_n_i})
    else $error("Freed chip selects not passed out in mode 0.");
  a_free_held: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    mode_o |-> free_chip_select_n_o == 4'hF)
    else $error("Freed chip selects active in mode 1.");
  a_lane_low: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    addr_i[0] |-> low_lane_n_o == 4'hF)
    else $error("Low lane active with odd address.");
  a_lane_high: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (!high_byte_enable_n_i) |-> high_lane_n_o == bank_sel_n_o)
    else $error("High lane does not follow bank select.");

  c_mode1_ram2: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    mode_o && !bank_sel_n_o[BANK_RAM2]);
  c_mode0_rom2: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    !mode_o && !bank_sel_n_o[BANK_ROM2]);
  c_byte_high: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    low_lane_n_o == 4'hF && high_lane_n_o != 4'hF);
  c_a21_block: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    !mode_o && jumper_o && !ctrl_chip_select_zero_n_i &&
    addr_i[ADDR_EXT_BIT]);
endmodule // bank_select_decoder
`default_nettype wire

// ===== ctrl_bus_model.sv
// Controller bus model: chip selects from the address windows.
// Assumes the bench drives the address and the cycle strobe.
`default_nettype none
module ctrl_bus_model
(
  // Cycle request
  input wire logic windows_on_i,
  input wire logic cycle_i,
  input wire logic [23:0] addr_i,
  // Levels on the freed select pins while no window is enabled.
  input wire logic [4:1] port_n_i,
  // Chip selects, active low
  output logic [4:0] cs_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] hit;
  // Windows are disjoint, so with windows enabled at most one select is low at any address.
  assign hit[1] = windows_on_i && addr_i[23:18] == 6'h01;
  assign hit[2] = windows_on_i && addr_i[23:18] == 6'h02;
  assign hit[3] = windows_on_i && addr_i[23:18] == 6'h03;
  assign hit[4] = windows_on_i && addr_i[23:12] == 12'h100;
  assign hit[0] = !(|hit[4:1]);
  // Between cycles every select that is not serving as a port pin returns to its inactive high level.
  // With no window enabled the other select pins serve as plain port
  // pins, so they show whatever levels the bench puts on them.
  assign cs_n_o = {windows_on_i ? ~(hit[4:1] & {4{cycle_i}}) : port_n_i,
    !(cycle_i && hit[0])};
endmodule // ctrl_bus_model
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the memory bank select decoder.
// Assumes the decoder package and the controller bus model are compiled.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import bank_decode_pkg::*;
  typedef struct packed {
    logic [3:0] sel;
    logic [3:0] lo;
    logic [3:0] hi;
    logic [3:0] free;
  } note_s;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic mode = 1'h1;
  logic jumper = 1'h0;
  logic windows_on = 1'h0;
  logic cycle = 1'h0;
  logic strobe = 1'h0;
  logic bhe_n = 1'h1;
  logic [23:0] addr = 24'h0;
  logic [3:0] port_n = 4'hF;
  logic [4:0] cs_n;
  logic [3:0] sel_n, lo_n, hi_n, free_n;
  logic mode_q, jumper_q;
  logic [2:0] cfg [5] = '{3'h4, 3'h6, 3'h7, 3'h0, 3'h1};
  note_s notes[$];
  int fail_count = 0;
  int checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  ctrl_bus_model PARTNER (.windows_on_i(windows_on), .cycle_i(cycle),
    .addr_i(addr), .port_n_i(port_n), .cs_n_o(cs_n));
  bank_select_decoder DUT (.ref_clk_i(ref_clk), .resetn_i(resetn),
    .mode_i(mode), .decoder_input_jumper_i(jumper), .addr_i(addr),
    .high_byte_enable_n_i(bhe_n), .ctrl_chip_select_zero_n_i(cs_n[0]),
    .ctrl_chip_select_one_n_i(cs_n[1]), .ctrl_chip_select_two_n_i(cs_n[2]),
    .ctrl_chip_select_three_n_i(cs_n[3]),
    .ctrl_chip_select_four_n_i(cs_n[4]), .bank_sel_n_o(sel_n),
    .low_lane_n_o(lo_n), .high_lane_n_o(hi_n), .free_chip_select_n_o(free_n),
    .mode_o(mode_q), .jumper_o(jumper_q));
  function automatic note_s expect_of(logic [4:0] cs, logic [23:0] a,
    logic b);
    note_s n;
    logic [3:0] hot;
    hot = 4'h0;
    if (mode)
      hot = {~cs[3] & ~jumper, ~cs[2], ~cs[1], ~cs[0]};
    else if (!cs[0] && !(jumper && a[21]))
      hot[{a[19], a[18]}] = 1'b1;
    n.sel = ~hot;
    n.lo = ~hot | {4{a[0]}};
    n.hi = ~hot | {4{b}};
    n.free = mode ? 4'hF : cs[4:1];
    return n;
  endfunction
  task automatic check(string what, logic [3:0] exp, logic [3:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic bus_cycle(logic [23:0] a, logic b, logic on);
    @(posedge ref_clk);
    #2;
    addr = a;
    bhe_n = b;
    cycle = on;
    port_n = mode ? 4'hF : 4'($urandom());
    strobe = 1'h1;
    #1;
    notes.push_back(expect_of(cs_n, a, b));
  endtask
  always @(negedge ref_clk)
  begin : watch
    note_s n;
    if (strobe && notes.size() > 0)
    begin
      n = notes.pop_front();
      check("bank_sel", n.sel, sel_n);
      check("low_lane", n.lo, lo_n);
      check("high_lane", n.hi, hi_n);
      check("free_cs", n.free, free_n);
    end
  end
  // Roughly 350 cycles are needed; 2000, over five times that, means a hang.
  initial
  begin
    #(25 * 2000);
    fail_count++;
    end_of_test();
  end
  initial
  begin : main
    logic [23:0] a;
    void'($urandom(4284));
    repeat (16) @(posedge ref_clk);
    #2;
    resetn = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      @(posedge ref_clk);
      #2;
      strobe = 1'b0;
      {mode, windows_on, jumper} = cfg[k];
      repeat (6) @(posedge ref_clk);
      #2;
      check("mode_o", {3'h0, mode}, {3'h0, mode_q});
      check("jumper_o", {3'h0, jumper}, {3'h0, jumper_q});
      for (int i = 0; i < 60; i++)
      begin
        a = 24'($urandom());
        a[23:22] = 2'h0;
        if (i % 5 == 0)
          a[23:12] = 12'h100;
        if (i % 5 == 1)
          a[21:18] = 4'(i % 4);
        bus_cycle(a, 1'($urandom()), i % 7 != 0);
      end
    end
    @(posedge ref_clk);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
